/* core/ofr_pkg.sv */
// Package with constants, encodings and carriers of the output relay and fault block
package ofr_pkg;

   localparam int OFR_ADDR_W = 8;
   localparam int OFR_DATA_W = 32;
   localparam int OFR_NCH = 2;
   localparam int OFR_NIRQ = 4;

   // Register byte offsets
   localparam logic [7:0] OFR_OFF_OUTPUT = 8'h00;
   localparam logic [7:0] OFR_OFF_COUPLE = 8'h04;
   localparam logic [7:0] OFR_OFF_RELAY = 8'h08;
   localparam logic [7:0] OFR_OFF_FAULT = 8'h0c;
   localparam logic [7:0] OFR_OFF_PON = 8'h10;
   localparam logic [7:0] OFR_OFF_COMP = 8'h14;
   localparam logic [7:0] OFR_OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFR_OFF_IRQ_MASK = 8'h1c;

   // Field positions
   localparam int OFR_CMD_STATE_BIT = 4;
   localparam int OFR_RELAY_CH_BIT = 4;
   localparam int OFR_FSRC_LSB = 4;
   localparam int OFR_FAULT_LVL_BIT = 8;
   localparam int OFR_PEND_MODE_LSB = 4;
   localparam int OFR_PEND_FLAG_LSB = 8;

   // Status byte summary bit positions
   localparam int OFR_SB_QUESTIONABLE_SUMMARY_SELECT_BIT = 3;
   localparam int OFR_SB_ESB_BIT = 5;
   localparam int OFR_SB_RQS_BIT = 6;
   localparam int OFR_SB_OPERATION_SUMMARY_SELECT_BIT = 7;

   // Interrupt status bits
   localparam int OFR_IRQ_APPLY0 = 0;
   localparam int OFR_IRQ_APPLY1 = 1;
   localparam int OFR_IRQ_FAULT = 2;
   localparam int OFR_IRQ_LOADED = 3;

   // Bit 1 is the turn-on switching, bit 0 the turn-off switching, 1 = hot
   typedef enum logic [1:0] {
      relay_dry_on_dry_off,
      relay_dry_on_hot_off,
      relay_hot_on_dry_off,
      relay_hot_on_hot_off
   } ofr_relay_t;

   typedef enum logic [2:0] {
      src_off,
      questionable_summary_select,
      standard_event_select,
      request_service_select,
      operation_summary_select
   } ofr_fsrc_t;

   typedef enum logic [1:0] {
      slow_local_compensation,
      slow_remote_compensation,
      fast_local_compensation,
      fast_remote_compensation
   } ofr_comp_t;

   typedef enum logic [1:0] {ch_off, ch_on_step, ch_on, ch_off_step} ofr_chan_st_t;
   typedef enum logic {ph_load, ph_run} ofr_phase_t;

   // Reset and factory values
   localparam logic OFR_COUPLE_RST = 1'b1;
   localparam logic OFR_PON_RST = 1'b0;
   localparam logic [3:0] OFR_IRQ_MASK_RST = 4'h0;
   localparam ofr_relay_t OFR_RELAY_FACTORY = relay_hot_on_hot_off;
   localparam ofr_comp_t OFR_COMP_RST = fast_remote_compensation;
   localparam logic [2:0] OFR_FSRC_MAX = 3'h4;

   typedef struct packed {
      logic level_en;
      logic sense_closed;
      logic sense_check;
   } ofr_chan_out_t;

   typedef struct packed {
      ofr_relay_t [1:0] relay;
      logic recall_slot_zero_at_power_on;
   } ofr_nv_t;

   typedef struct packed {
      logic [OFR_ADDR_W-1:0] addr;
      logic [OFR_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ofr_bus_req_t;

   typedef struct packed {
      ofr_phase_t phase;
      logic [1:0] nv_valid_sync;
      logic [1:0] nv_blank_sync;
      ofr_nv_t nv_s1;
      ofr_nv_t nv_s2;
      logic [1:0] out_en;
      logic couple;
      ofr_relay_t [1:0] active;
      ofr_relay_t [1:0] pend_mode;
      logic [1:0] pend;
      ofr_chan_st_t [1:0] cst;
      ofr_chan_out_t [1:0] chan;
      logic fault_en;
      ofr_fsrc_t fault_src;
      logic fault;
      logic pon;
      ofr_comp_t comp;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
      logic [OFR_DATA_W-1:0] rdata;
      logic nv_write;
      ofr_nv_t nv_data;
      logic recall;
   } ofr_state_t;

endpackage

/* core/ofr_ctrl.sv */
// Output enable, coupling, relay sequencing, fault indicator and power-on control
// Behaviour
// - Per-channel output enable, readable, cleared at reset
// - Coupled enable command switches both outputs
// - Uncoupled, unnamed command acts on main output
// - New relay mode pending until output off
// - Relay mode per output, never coupled
// - Relay modes stored non-volatile, reloaded at power-up
// - Factory relay mode is hot-on hot-off
// - Relay mode: turn-on and turn-off dry/hot
// - Hot turn-on skips open sense check
// - Hot turn-on programs level before sense relay; hot turn-off opens sense relay before level
// - Fault indicator enable, settable and readable
// - Fault source picks status bit 3/5/6/7
// - Off source routes nothing to indicator
// - Power-on choice stored: defaults or recall slot 0
// - Four compensation settings, fast remote default
// - Coupling is coupled or uncoupled
`timescale 1ns/1ps
`default_nettype none

module ofr_ctrl
   import ofr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [OFR_ADDR_W-1:0] i_addr,
   input wire logic [OFR_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [OFR_DATA_W-1:0] o_rdata,
   input wire logic [7:0] i_status_byte,
   input wire logic i_nv_valid,
   input wire logic i_nv_blank,
   input wire ofr_nv_t i_nv_data,
   output logic o_nv_write,
   output ofr_nv_t o_nv_data,
   output logic o_recall_slot_zero,
   output ofr_chan_out_t [1:0] o_chan,
   output ofr_comp_t o_comp,
   output logic o_fault_indicator_out,
   output logic o_irq
);

   ofr_state_t st_ff;
   ofr_state_t nxt_st;

   function automatic logic reg_hit(input logic [OFR_ADDR_W-1:0] a,
                                    input logic [OFR_ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction

   function automatic logic fsrc_bit(input ofr_fsrc_t s, input logic [7:0] sb);
      case (s)
         questionable_summary_select: fsrc_bit = sb[OFR_SB_QUESTIONABLE_SUMMARY_SELECT_BIT];
         standard_event_select: fsrc_bit = sb[OFR_SB_ESB_BIT];
         request_service_select: fsrc_bit = sb[OFR_SB_RQS_BIT];
         operation_summary_select: fsrc_bit = sb[OFR_SB_OPERATION_SUMMARY_SELECT_BIT];
         default: fsrc_bit = 1'b0;
      endcase
   endfunction

   logic run;
   assign run = (st_ff.phase == ph_run);

   always_comb begin
      logic [3:0] ev;
      logic ch;
      logic onoff;
      ev = 4'h0;
      ch = 1'b0;
      onoff = 1'b0;
      nxt_st = st_ff;
      nxt_st.nv_valid_sync = {st_ff.nv_valid_sync[0], i_nv_valid};
      nxt_st.nv_blank_sync = {st_ff.nv_blank_sync[0], i_nv_blank};
      nxt_st.nv_s1 = i_nv_data;
      nxt_st.nv_s2 = st_ff.nv_s1;
      nxt_st.nv_write = 1'b0;
      nxt_st.recall = 1'b0;
      nxt_st.rdata = '0;

      // Power-up load from non-volatile storage
      case (st_ff.phase)
         ph_load: begin
            if (st_ff.nv_valid_sync[1]) begin
               nxt_st.phase = ph_run;
               ev[OFR_IRQ_LOADED] = 1'b1;
               if (st_ff.nv_blank_sync[1]) begin
                  // Erased storage gets the factory image written back
                  nxt_st.active = {OFR_RELAY_FACTORY, OFR_RELAY_FACTORY};
                  nxt_st.pon = OFR_PON_RST;
                  nxt_st.nv_data.relay = {OFR_RELAY_FACTORY, OFR_RELAY_FACTORY};
                  nxt_st.nv_data.recall_slot_zero_at_power_on = OFR_PON_RST;
                  nxt_st.nv_write = 1'b1;
               end else begin
                  nxt_st.active = st_ff.nv_s2.relay;
                  nxt_st.pon = st_ff.nv_s2.recall_slot_zero_at_power_on;
                  nxt_st.nv_data = st_ff.nv_s2;
                  nxt_st.recall = st_ff.nv_s2.recall_slot_zero_at_power_on;
               end
               nxt_st.pend_mode = nxt_st.active;
            end
         end
         ph_run: begin
         end
         default: begin
            nxt_st.phase = ph_load;
         end
      endcase

      // Relay sequencing per channel; active mode only changes while off
      for (int i = 0; i < OFR_NCH; i++) begin
         if (st_ff.pend[i] && st_ff.cst[i] == ch_off && !st_ff.out_en[i]) begin
            nxt_st.active[i] = st_ff.pend_mode[i];
            nxt_st.pend[i] = 1'b0;
            ev[i] = 1'b1;
         end
         case (st_ff.cst[i])
            ch_off: begin
               nxt_st.chan[i] = '0;
               if (st_ff.out_en[i]) begin
                  nxt_st.cst[i] = ch_on_step;
                  if (st_ff.active[i][1]) begin
                     // Hot on: level first, relay later, no lead check
                     nxt_st.chan[i].level_en = 1'b1;
                  end else begin
                     nxt_st.chan[i].sense_closed = 1'b1;
                     nxt_st.chan[i].sense_check = 1'b1;
                  end
               end
            end
            ch_on_step: begin
               nxt_st.chan[i].level_en = 1'b1;
               nxt_st.chan[i].sense_closed = 1'b1;
               nxt_st.chan[i].sense_check = 1'b0;
               nxt_st.cst[i] = ch_on;
            end
            ch_on: begin
               if (!st_ff.out_en[i]) begin
                  nxt_st.cst[i] = ch_off_step;
                  if (st_ff.active[i][0]) begin
                     nxt_st.chan[i].sense_closed = 1'b0;
                  end else begin
                     nxt_st.chan[i].level_en = 1'b0;
                  end
               end
            end
            ch_off_step: begin
               nxt_st.chan[i] = '0;
               nxt_st.cst[i] = ch_off;
            end
            default: begin
               nxt_st.chan[i] = '0;
               nxt_st.cst[i] = ch_off;
            end
         endcase
      end

      // Register writes; ignored until the power-up load is done
      if (i_wr && run) begin
         if (reg_hit(i_addr, OFR_OFF_OUTPUT)) begin
            onoff = i_wdata[OFR_CMD_STATE_BIT];
            if (st_ff.couple) begin
               nxt_st.out_en = {onoff, onoff};
            end else begin
               case (i_wdata[1:0])
                  2'h0: nxt_st.out_en[0] = onoff;
                  2'h1: nxt_st.out_en[0] = onoff;
                  2'h2: nxt_st.out_en[1] = onoff;
                  default: nxt_st.out_en = st_ff.out_en;
               endcase
            end
         end
         if (reg_hit(i_addr, OFR_OFF_COUPLE)) begin
            nxt_st.couple = i_wdata[0];
         end
         if (reg_hit(i_addr, OFR_OFF_RELAY)) begin
            ch = i_wdata[OFR_RELAY_CH_BIT];
            // Only the named channel, coupling does not matter
            nxt_st.pend[ch] = 1'b1;
            nxt_st.pend_mode[ch] = ofr_relay_t'(i_wdata[1:0]);
            nxt_st.nv_data.relay[ch] = ofr_relay_t'(i_wdata[1:0]);
            nxt_st.nv_write = 1'b1;
         end
         if (reg_hit(i_addr, OFR_OFF_FAULT)) begin
            nxt_st.fault_en = i_wdata[0];
            if (i_wdata[OFR_FSRC_LSB+2:OFR_FSRC_LSB] <= OFR_FSRC_MAX) begin
               nxt_st.fault_src = ofr_fsrc_t'(i_wdata[OFR_FSRC_LSB+2:OFR_FSRC_LSB]);
            end
         end
         if (reg_hit(i_addr, OFR_OFF_PON)) begin
            nxt_st.pon = i_wdata[0];
            nxt_st.nv_data.recall_slot_zero_at_power_on = i_wdata[0];
            nxt_st.nv_write = 1'b1;
         end
         if (reg_hit(i_addr, OFR_OFF_COMP)) begin
            nxt_st.comp = ofr_comp_t'(i_wdata[1:0]);
         end
         if (reg_hit(i_addr, OFR_OFF_IRQ_MASK)) begin
            nxt_st.irq_mask = i_wdata[3:0];
         end
      end

      // Fault indicator, registered so the pin never glitches
      nxt_st.fault = st_ff.fault_en && fsrc_bit(st_ff.fault_src, i_status_byte);
      ev[OFR_IRQ_FAULT] = nxt_st.fault && !st_ff.fault;

      // Reads answer in the next cycle; unmapped reads give zero
      if (i_rd) begin
         if (reg_hit(i_addr, OFR_OFF_OUTPUT)) begin
            nxt_st.rdata[1:0] = st_ff.out_en;
         end
         if (reg_hit(i_addr, OFR_OFF_COUPLE)) begin
            nxt_st.rdata[0] = st_ff.couple;
         end
         if (reg_hit(i_addr, OFR_OFF_RELAY)) begin
            nxt_st.rdata[3:0] = st_ff.active;
            nxt_st.rdata[OFR_PEND_MODE_LSB+3:OFR_PEND_MODE_LSB] = st_ff.pend_mode;
            nxt_st.rdata[OFR_PEND_FLAG_LSB+1:OFR_PEND_FLAG_LSB] = st_ff.pend;
         end
         if (reg_hit(i_addr, OFR_OFF_FAULT)) begin
            nxt_st.rdata[0] = st_ff.fault_en;
            nxt_st.rdata[OFR_FSRC_LSB+2:OFR_FSRC_LSB] = st_ff.fault_src;
            nxt_st.rdata[OFR_FAULT_LVL_BIT] = st_ff.fault;
         end
         if (reg_hit(i_addr, OFR_OFF_PON)) begin
            nxt_st.rdata[0] = st_ff.pon;
         end
         if (reg_hit(i_addr, OFR_OFF_COMP)) begin
            nxt_st.rdata[1:0] = st_ff.comp;
         end
         if (reg_hit(i_addr, OFR_OFF_IRQ_STAT)) begin
            nxt_st.rdata[3:0] = st_ff.irq_stat;
            nxt_st.irq_stat = 4'h0;
         end
         if (reg_hit(i_addr, OFR_OFF_IRQ_MASK)) begin
            nxt_st.rdata[3:0] = st_ff.irq_mask;
         end
      end

      // A new event beats the read clear
      nxt_st.irq_stat = nxt_st.irq_stat | ev;
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st_ff <= '0;
         st_ff.couple <= OFR_COUPLE_RST;
         st_ff.active <= {OFR_RELAY_FACTORY, OFR_RELAY_FACTORY};
         st_ff.pend_mode <= {OFR_RELAY_FACTORY, OFR_RELAY_FACTORY};
         st_ff.nv_data.relay <= {OFR_RELAY_FACTORY, OFR_RELAY_FACTORY};
         st_ff.pon <= OFR_PON_RST;
         st_ff.comp <= OFR_COMP_RST;
         st_ff.irq_mask <= OFR_IRQ_MASK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_rdata = st_ff.rdata;
   assign o_nv_write = st_ff.nv_write;
   assign o_nv_data = st_ff.nv_data;
   assign o_recall_slot_zero = st_ff.recall;
   assign o_chan = st_ff.chan;
   assign o_comp = st_ff.comp;
   assign o_fault_indicator_out = st_ff.fault;
   assign o_irq = st_ff.irq;

   AST_RESET_OFF: assert property (@(posedge i_clk)
      !i_reset_n |=> (st_ff.out_en == 2'b00) && (st_ff.chan == '0))
      else $error("Outputs not disabled after reset");

   AST_COUPLED_BOTH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_OUTPUT && st_ff.couple)
      |=> st_ff.out_en == {2{$past(i_wdata[OFR_CMD_STATE_BIT])}})
      else $error("Coupled command did not switch both outputs");

   AST_UNCOUPLED_MAIN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_OUTPUT && !st_ff.couple && i_wdata[1:0] == 2'h0)
      |=> (st_ff.out_en[0] == $past(i_wdata[OFR_CMD_STATE_BIT]))
         && (st_ff.out_en[1] == $past(st_ff.out_en[1])))
      else $error("Unnamed command did not act on main output alone");

   AST_PEND_HELD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (run && st_ff.cst[0] != ch_off) |=> st_ff.active[0] == $past(st_ff.active[0]))
      else $error("Relay mode changed while output not off");

   AST_RELAY_SEPARATE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_RELAY && !i_wdata[OFR_RELAY_CH_BIT])
      |=> (st_ff.pend_mode[1] == $past(st_ff.pend_mode[1])) && st_ff.pend[0] && st_ff.nv_write)
      else $error("Relay mode write leaked to other output");

   AST_FACTORY_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!run && st_ff.nv_valid_sync[1] && st_ff.nv_blank_sync[1])
      |=> st_ff.active == {relay_hot_on_hot_off, relay_hot_on_hot_off} && run)
      else $error("Blank storage did not give hot-hot modes");

   AST_HOT_ON_SEQ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (st_ff.cst[0] == ch_off && st_ff.out_en[0] && st_ff.active[0][1])
      |=> (st_ff.chan[0].level_en && !st_ff.chan[0].sense_closed && !st_ff.chan[0].sense_check)
         ##1 (st_ff.chan[0].level_en && st_ff.chan[0].sense_closed))
      else $error("Hot turn-on order wrong");

   AST_FAULT_OUT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> st_ff.fault == ($past(st_ff.fault_en)
         && fsrc_bit($past(st_ff.fault_src), $past(i_status_byte))))
      else $error("Fault indicator does not follow enable and source");

   AST_FAULT_OFF_SRC: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (st_ff.fault_src == src_off) [*2] |-> !st_ff.fault)
      else $error("Fault indicator set with source off");

   AST_UNCOUPLED_SECOND: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_OUTPUT && !st_ff.couple && i_wdata[1:0] == 2'h2)
      |=> (st_ff.out_en[1] == $past(i_wdata[OFR_CMD_STATE_BIT]))
         && (st_ff.out_en[0] == $past(st_ff.out_en[0])))
      else $error("Named command did not act on its channel alone");

   AST_PEND_APPLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (run && st_ff.pend[1] && st_ff.cst[1] == ch_off && !st_ff.out_en[1])
      |=> (st_ff.active[1] == $past(st_ff.pend_mode[1])))
      else $error("Pending relay mode not applied while off");

   AST_DRY_ON_SEQ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (st_ff.cst[1] == ch_off && st_ff.out_en[1] && !st_ff.active[1][1])
      |=> (!st_ff.chan[1].level_en && st_ff.chan[1].sense_closed && st_ff.chan[1].sense_check)
         ##1 (st_ff.chan[1].level_en && st_ff.chan[1].sense_closed))
      else $error("Dry turn-on order wrong");

   AST_HOT_OFF_SEQ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (st_ff.cst[1] == ch_on && !st_ff.out_en[1] && st_ff.active[1][0])
      |=> (st_ff.chan[1].level_en && !st_ff.chan[1].sense_closed)
         ##1 (st_ff.chan[1] == '0))
      else $error("Hot turn-off order wrong");

   AST_DRY_OFF_SEQ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (st_ff.cst[1] == ch_on && !st_ff.out_en[1] && !st_ff.active[1][0])
      |=> (!st_ff.chan[1].level_en && st_ff.chan[1].sense_closed)
         ##1 (st_ff.chan[1] == '0))
      else $error("Dry turn-off order wrong");

   AST_NV_RELOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!run && st_ff.nv_valid_sync[1] && !st_ff.nv_blank_sync[1])
      |=> (st_ff.active == $past(st_ff.nv_s2.relay)) && run)
      else $error("Stored relay modes not reloaded");

   AST_RECALL: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!run && st_ff.nv_valid_sync[1] && !st_ff.nv_blank_sync[1])
      |=> st_ff.recall == $past(st_ff.nv_s2.recall_slot_zero_at_power_on))
      else $error("Power-on recall choice not followed");

   AST_FAULT_EN_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_FAULT)
      |=> st_ff.fault_en == $past(i_wdata[0]))
      else $error("Fault indicator enable not written");

   AST_FAULT_SRC_REFUSED: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_FAULT
         && i_wdata[OFR_FSRC_LSB+2:OFR_FSRC_LSB] > OFR_FSRC_MAX)
      |=> st_ff.fault_src == $past(st_ff.fault_src))
      else $error("Unknown fault source code accepted");

   AST_COMP_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_COMP)
      |=> st_ff.comp == $past(i_wdata[1:0]))
      else $error("Compensation setting not written");

   AST_COUPLE_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_wr && run && i_addr == OFR_OFF_COUPLE)
      |=> st_ff.couple == $past(i_wdata[0]))
      else $error("Coupling setting not written");

endmodule

`default_nettype wire

/* verification/ofr_nv_model.sv */
// Non-volatile settings store facing the block's load and save port
`timescale 1ns/1ps
`default_nettype none
module ofr_nv_model
   import ofr_pkg::*;
#(parameter int LOAD_DLY = 3)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_nv_write,
   input wire ofr_nv_t i_nv_data,
   output logic o_nv_valid,
   output logic o_nv_blank,
   output ofr_nv_t o_nv_data
);
   ofr_nv_t image_ff = '0;
   logic blank_ff = 1'b1;
   int cnt_ff = 0;

   // Image kept through reset, as storage keeps it through power cycles
   always @(posedge i_clk) begin
      if (i_nv_write === 1'b1) begin
         image_ff <= i_nv_data;
         blank_ff <= 1'b0;
      end
      if (!i_reset_n)
         cnt_ff <= 0;
      else if (cnt_ff < LOAD_DLY)
         cnt_ff <= cnt_ff + 1;
   end

   assign o_nv_valid = (cnt_ff == LOAD_DLY);
   assign o_nv_blank = blank_ff;
   // Inverted before valid, so an early load is caught
   assign o_nv_data = o_nv_valid ? image_ff : ~image_ff;
endmodule
`default_nettype wire

/* verification/ofr_ctrl_tb_top.sv */
// Self-checking bench of the output relay and fault indicator block
`timescale 1ns/1ps
`default_nettype none
module ofr_ctrl_tb_top
   import ofr_pkg::*;
;
   logic i_clk, i_reset_n, i_wr, i_rd, nv_valid, nv_blank, nv_write, recall, fault, irq;
   logic [7:0] i_addr, i_status_byte;
   logic [31:0] i_wdata, o_rdata, rv;
   logic [1:0] prev;
   ofr_nv_t nv_in, nv_out, last_nv;
   ofr_chan_out_t [1:0] chan;
   ofr_comp_t comp;
   int err_total, check_count, recall_cnt;

   ofr_ctrl u_dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_status_byte(i_status_byte),
      .i_nv_valid(nv_valid), .i_nv_blank(nv_blank), .i_nv_data(nv_in),
      .o_nv_write(nv_write), .o_nv_data(nv_out), .o_recall_slot_zero(recall),
      .o_chan(chan), .o_comp(comp), .o_fault_indicator_out(fault), .o_irq(irq));

   ofr_nv_model u_nv (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_nv_write(nv_write), .i_nv_data(nv_out),
      .o_nv_valid(nv_valid), .o_nv_blank(nv_blank), .o_nv_data(nv_in));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      if (nv_write === 1'b1)
         last_nv <= nv_out;
      if (recall === 1'b1)
         recall_cnt <= recall_cnt + 1;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, rv);
      chk("rdata", e, rv & m);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic sb(input logic [7:0] v);
      @(posedge i_clk);
      i_status_byte <= v;
   endtask

   // Latency tolerant: wait for a change, then demand step and final shape
   task automatic seq(input int ch, input logic [2:0] from, input logic [2:0] st,
                      input logic [2:0] fin);
      int n;
      n = 0;
      #1;
      while (chan[ch] === from && n < 6) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk("chan step", 32'(st), 32'(chan[ch]));
      if (n == 6)
         summarize();
      cyc(1);
      chk("chan final", 32'(fin), 32'(chan[ch]));
   endtask

   task automatic do_reset();
      int n;
      n = 0;
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rv = '0;
      while (rv[3] !== 1'b1 && n < 20) begin
         rd(OFR_OFF_IRQ_STAT, rv);
         n++;
      end
      chk("load done", 32'h1, 32'(rv[3]));
      if (rv[3] !== 1'b1)
         summarize();
   endtask

   task automatic t_reset_vals();
      chk("recall", 32'h0, 32'(recall_cnt));
      chk("nv image", 32'h1e, 32'(last_nv));
      chk("chan", 32'h0, 32'(chan));
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h0);
      rdc(OFR_OFF_COUPLE, 32'h1, 32'h1);
      rdc(OFR_OFF_RELAY, 32'h30f, 32'hf);
      rdc(OFR_OFF_COMP, 32'h3, 32'h3);
      for (int c = 0; c < 4; c++) begin
         wr(OFR_OFF_COMP, 32'(c));
         rdc(OFR_OFF_COMP, 32'h3, 32'(c));
         chk("comp", 32'(c), 32'(comp));
      end
   endtask

   task automatic t_couple();
      wr(OFR_OFF_OUTPUT, 32'h10);
      seq(0, 3'b000, 3'b100, 3'b110);
      chk("chan1", 32'h6, 32'(chan[1]));
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h3);
      wr(OFR_OFF_OUTPUT, 32'h00);
      seq(0, 3'b110, 3'b100, 3'b000);
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h0);
      wr(OFR_OFF_COUPLE, 32'h0);
      rdc(OFR_OFF_COUPLE, 32'h1, 32'h0);
      wr(OFR_OFF_OUTPUT, 32'h10);
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h1);
      wr(OFR_OFF_OUTPUT, 32'h12);
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h3);
      wr(OFR_OFF_OUTPUT, 32'h01);
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h2);
      wr(OFR_OFF_OUTPUT, 32'h02);
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h0);
      wr(OFR_OFF_OUTPUT, 32'h13);
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h0);
   endtask

   // Few stores only; the storage wears out
   task automatic t_relay();
      prev = 2'h3;
      for (int m = 0; m < 4; m++) begin
         wr(OFR_OFF_OUTPUT, 32'h12);
         seq(1, 3'b000, prev[1] ? 3'b100 : 3'b011, 3'b110);
         wr(OFR_OFF_RELAY, 32'h10 | 32'(m));
         cyc(3);
         chk("nv relay", 32'(m), 32'(last_nv.relay[1]));
         rdc(OFR_OFF_RELAY, 32'h3cf, {22'h0, 2'b10, 2'(m), 2'b00, prev, 2'b11});
         wr(OFR_OFF_OUTPUT, 32'h02);
         seq(1, 3'b110, prev[0] ? 3'b100 : 3'b010, 3'b000);
         cyc(2);
         rdc(OFR_OFF_RELAY, 32'h30f, {28'h0, 2'(m), 2'b11});
         prev = 2'(m);
      end
      wr(OFR_OFF_COUPLE, 32'h1);
      wr(OFR_OFF_RELAY, 32'h0);
      cyc(3);
      rdc(OFR_OFF_RELAY, 32'h30f, 32'hc);
   endtask

   task automatic t_fault();
      int bp[4] = '{3, 5, 6, 7};
      wr(OFR_OFF_IRQ_MASK, 32'h4);
      rdc(OFR_OFF_IRQ_MASK, 32'hf, 32'h4);
      for (int s = 1; s <= 4; s++) begin
         wr(OFR_OFF_FAULT, 32'h1 | 32'(s << 4));
         rdc(OFR_OFF_FAULT, 32'h71, 32'h1 | 32'(s << 4));
         sb(~(8'h1 << bp[s-1]));
         cyc(3);
         chk("fault", 32'h0, 32'(fault));
         sb(8'h1 << bp[s-1]);
         cyc(3);
         chk("fault", 32'h1, 32'(fault));
         chk("irq", 32'h1, 32'(irq));
         rdc(OFR_OFF_IRQ_STAT, 32'h4, 32'h4);
         cyc(1);
         chk("irq", 32'h0, 32'(irq));
         sb(8'h0);
      end
      // Masked event stays sticky but quiet
      wr(OFR_OFF_IRQ_MASK, 32'h0);
      sb(8'h80);
      cyc(3);
      chk("irq", 32'h0, 32'(irq));
      rdc(OFR_OFF_IRQ_STAT, 32'h4, 32'h4);
      wr(OFR_OFF_FAULT, 32'h1);
      sb(8'hff);
      cyc(3);
      chk("fault", 32'h0, 32'(fault));
      wr(OFR_OFF_FAULT, 32'h40);
      cyc(3);
      chk("fault", 32'h0, 32'(fault));
      rdc(OFR_OFF_FAULT, 32'h1, 32'h0);
      wr(OFR_OFF_FAULT, 32'h71);
      rdc(OFR_OFF_FAULT, 32'h71, 32'h41);
      sb(8'h0);
   endtask

   task automatic t_pon();
      wr(OFR_OFF_PON, 32'h1);
      cyc(3);
      chk("nv recall", 32'h1, 32'(last_nv.recall_slot_zero_at_power_on));
      rdc(OFR_OFF_PON, 32'h1, 32'h1);
      do_reset();
      chk("recall", 32'h1, 32'(recall_cnt));
      rdc(OFR_OFF_PON, 32'h1, 32'h1);
      rdc(OFR_OFF_RELAY, 32'h30f, 32'hc);
      rdc(OFR_OFF_OUTPUT, 32'h3, 32'h0);
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      $display("mismatch watchdog expected done seen hang");
      summarize();
   end

   initial begin
      i_reset_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      i_status_byte = '0;
      do_reset();
      t_reset_vals();
      t_couple();
      t_relay();
      t_fault();
      t_pon();
      summarize();
   end
endmodule
`default_nettype wire
